// ===== pin_source.sv
// Pin-side model: count pins and interrupt inputs, idle high as with pull-ups
`timescale 1ns/100ps
module pin_source (
  input wire logic i_clk,
  output logic [3:0] o_pins
);
  initial o_pins = 4'hF;
  // The low level is held three clocks and the high level four, so the two-flop sampler cannot miss either
  task automatic pulse_low(input int idx);
    @(negedge i_clk);
    o_pins[idx] = 1'b0;
    repeat (3) @(negedge i_clk);
    o_pins[idx] = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask : pulse_low
  task automatic set_pin(input int idx, input logic v);
    @(negedge i_clk);
    o_pins[idx] = v;
  endtask : set_pin
endmodule : pin_source

// ===== pin_sync.sv
// Two-flop synchroniser with edge detection for one external pin
`timescale 1ns/100ps
module pin_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall,
  output logic o_rise
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges are seen in the same cycle as the synchronised level changes
  assign o_level = sync_q;
  assign o_fall = prev_q & ~sync_q;
  assign o_rise = ~prev_q & sync_q;

endmodule : pin_sync

// ===== timer01_pkg.sv
// Shared constants and types for the timer 0/1 split-mode and run/flag control block
package timer01_pkg;

  // Bit positions in timer_run_and_flag_control
  localparam int unsigned CTL_TIMER1_OVERFLOW_FLAG = 7;
  localparam int unsigned CTL_TIMER1_RUN_BIT = 6;
  localparam int unsigned CTL_TIMER0_OVERFLOW_FLAG = 5;
  localparam int unsigned CTL_TIMER0_RUN_BIT = 4;
  localparam int unsigned CTL_EXT_IRQ1_PENDING = 3;
  localparam int unsigned CTL_EXT_IRQ1_TYPE_SELECT = 2;
  localparam int unsigned CTL_EXT_IRQ0_PENDING = 1;
  localparam int unsigned CTL_EXT_IRQ0_TYPE_SELECT = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Bit positions in timer_mode_register
  localparam int unsigned MODE_TIMER1_GATE_ENABLE = 7;
  localparam int unsigned MODE_TIMER1_COUNT_SOURCE_SELECT = 6;
  localparam int unsigned MODE_TIMER1_MODE_FIELD_HI = 5;
  localparam int unsigned MODE_TIMER1_MODE_FIELD_LO = 4;
  localparam int unsigned MODE_TIMER0_GATE_ENABLE = 3;
  localparam int unsigned MODE_TIMER0_COUNT_SOURCE_SELECT = 2;
  localparam int unsigned MODE_TIMER0_MODE_FIELD_HI = 1;
  localparam int unsigned MODE_TIMER0_MODE_FIELD_LO = 0;

  // Index of each timer byte on the byte write strobes
  localparam int unsigned BYTE_TIMER0_LOW = 0;
  localparam int unsigned BYTE_TIMER0_HIGH = 1;
  localparam int unsigned BYTE_TIMER1_LOW = 2;
  localparam int unsigned BYTE_TIMER1_HIGH = 3;

  // Index of each pin on the synchroniser bank and vector acknowledges
  localparam int unsigned PIN_TIMER0_COUNT = 0;
  localparam int unsigned PIN_TIMER1_COUNT = 1;
  localparam int unsigned PIN_EXT_IRQ0 = 2;
  localparam int unsigned PIN_EXT_IRQ1 = 3;
  localparam int unsigned ACK_EXT_IRQ0 = 0;
  localparam int unsigned ACK_TIMER0 = 1;
  localparam int unsigned ACK_EXT_IRQ1 = 2;
  localparam int unsigned ACK_TIMER1 = 3;

  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

endpackage : timer01_pkg

// ===== timer01_split_mode_and_control.sv
// Timer 0/1 counters with split mode and the timer run and flag control register
//
// How it works
// - Timer 0 mode three splits timer 0 into two independent 8-bit counters in its low and high bytes.
// - In split mode the low-byte counter uses timer 0's run, source select, gate and overflow flag.
// - In split mode the low byte counts its timer clock or falling edges of the count pin as selected.
// - In split mode the high byte is only a timer on the system or prescaled clock, never a pin.
// - In split mode the high byte counts only while timer 1's run bit is set and ignores any gate.
// - In split mode a high-byte overflow sets timer 1's overflow flag and so its interrupt request.
// - With timer 0 split, timer 1 runs in modes 0 to 2 but counts no pin events and never sets its flag.
// - With timer 0 split, timer 1 overflows still reach the serial ports as a baud-rate tick.
// - With timer 0 split, timer 1 runs whenever its mode is 0, 1 or 2 and stops in mode 3.
// - Timer 1's overflow flag in bit 7 is set by hardware, cleared by software or on vectoring.
// - Vectoring to the timer 1 service routine clears timer 1's overflow flag.
// - Timer 1 mode three leaves timer 1 inactive with no counting.
// - With its gate bit set timer 0, and timer 1 outside split mode, counts only while run is set and its interrupt input is active.
`timescale 1ns/100ps
module timer01_split_mode_and_control
  import timer01_pkg::*;
#(
  parameter int unsigned NUM_PINS = 4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_ctl_wdata,
  input wire logic [7:0] i_timer_mode_register,
  input wire logic [3:0] i_byte_wr,
  input wire logic [7:0] i_byte_wdata,
  input wire logic i_timer0_sysclk_select,
  input wire logic i_timer1_sysclk_select,
  input wire logic i_prescale_tick,
  input wire logic i_ext_irq0_polarity,
  input wire logic i_ext_irq1_polarity,
  input wire logic i_timer0_count_pin,
  input wire logic i_timer1_count_pin,
  input wire logic i_ext_irq0_input,
  input wire logic i_ext_irq1_input,
  input wire logic [3:0] i_vector_ack,
  output logic [7:0] o_ctl_rdata,
  output logic [7:0] o_timer0_low_byte,
  output logic [7:0] o_timer0_high_byte,
  output logic [7:0] o_timer1_low_byte,
  output logic [7:0] o_timer1_high_byte,
  output logic o_timer0_irq,
  output logic o_timer1_irq,
  output logic o_ext_irq0_irq,
  output logic o_ext_irq1_irq,
  output logic o_timer1_baud_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // Counter step: returns {overflow, high byte, low byte}

  function automatic logic [16:0] step_timer(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    logic [16:0] res;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c16 = {1'b0, hi, lo} + 17'h0_0001;
    c8 = {1'b0, lo} + 9'h001;
    unique case (timer_mode_t'(mode))
      // Upper three bits of the low byte are left untouched
      MODE_13BIT: res = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      MODE_16BIT: res = c16;
      MODE_RELOAD: res = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
      // Split: the low byte alone wraps, the high byte is stepped elsewhere
      MODE_SPLIT: res = {c8[8], hi, c8[7:0]};
    endcase
    return res;
  endfunction : step_timer

  // Picks the high-active or the low-active view of an input by its polarity bit
  function automatic logic by_polarity(
    input logic pol,
    input logic if_high,
    input logic if_low
  );
    return pol ? if_high : if_low;
  endfunction : by_polarity

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Pins change at any time, so each passes two flops before any logic reads it

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_fall;
  logic [NUM_PINS-1:0] pin_rise;

  assign pin_raw[PIN_TIMER0_COUNT] = i_timer0_count_pin;
  assign pin_raw[PIN_TIMER1_COUNT] = i_timer1_count_pin;
  assign pin_raw[PIN_EXT_IRQ0] = i_ext_irq0_input;
  assign pin_raw[PIN_EXT_IRQ1] = i_ext_irq1_input;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pin_sync u_sync (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pin(pin_raw[g]),
      .o_level(pin_level[g]),
      .o_fall(pin_fall[g]),
      .o_rise(pin_rise[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] tl0_q;
  logic [7:0] tl0_d;
  logic [7:0] th0_q;
  logic [7:0] th0_d;
  logic [7:0] tl1_q;
  logic [7:0] tl1_d;
  logic [7:0] th1_q;
  logic [7:0] th1_d;
  logic baud_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of mode and control fields
  // The mode register is read live; it comes from logic on this same clock

  wire [1:0] t0_mode = i_timer_mode_register[MODE_TIMER0_MODE_FIELD_HI:MODE_TIMER0_MODE_FIELD_LO];
  wire [1:0] t1_mode = i_timer_mode_register[MODE_TIMER1_MODE_FIELD_HI:MODE_TIMER1_MODE_FIELD_LO];
  wire t0_gate = i_timer_mode_register[MODE_TIMER0_GATE_ENABLE];
  wire t1_gate = i_timer_mode_register[MODE_TIMER1_GATE_ENABLE];
  wire t0_count_src = i_timer_mode_register[MODE_TIMER0_COUNT_SOURCE_SELECT];
  wire t1_count_src = i_timer_mode_register[MODE_TIMER1_COUNT_SOURCE_SELECT];
  wire t0_run_bit = ctl_q[CTL_TIMER0_RUN_BIT];
  wire t1_run_bit = ctl_q[CTL_TIMER1_RUN_BIT];
  wire irq0_type = ctl_q[CTL_EXT_IRQ0_TYPE_SELECT];
  wire irq1_type = ctl_q[CTL_EXT_IRQ1_TYPE_SELECT];

  wire split = (t0_mode == MODE_SPLIT);
  // Mode three parks timer 1; with timer 0 split it is timer 1's only stop
  wire t1_mode_live = (t1_mode != MODE_SPLIT);

  // Interrupt inputs are active at the configured polarity (1 = high)
  wire irq0_active = by_polarity(i_ext_irq0_polarity, pin_level[PIN_EXT_IRQ0], ~pin_level[PIN_EXT_IRQ0]);
  wire irq1_active = by_polarity(i_ext_irq1_polarity, pin_level[PIN_EXT_IRQ1], ~pin_level[PIN_EXT_IRQ1]);
  wire irq0_edge = by_polarity(i_ext_irq0_polarity, pin_rise[PIN_EXT_IRQ0], pin_fall[PIN_EXT_IRQ0]);
  wire irq1_edge = by_polarity(i_ext_irq1_polarity, pin_rise[PIN_EXT_IRQ1], pin_fall[PIN_EXT_IRQ1]);

  // Timer clock: system clock every cycle, or the prescaled tick
  wire t0_tick = i_timer0_sysclk_select | i_prescale_tick;
  wire t1_tick = i_timer1_sysclk_select | i_prescale_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer 0 (low byte in split mode)

  // The gate lets an external level time a pulse width
  wire t0_enable = t0_run_bit & (~t0_gate | irq0_active);
  wire t0_src_tick = t0_count_src ? pin_fall[PIN_TIMER0_COUNT] : t0_tick;
  wire t0_inc = t0_enable & t0_src_tick;
  wire [16:0] t0_next = step_timer(t0_mode, tl0_q, th0_q);
  wire t0_ovf = t0_inc & t0_next[16];

  ////////////////////////////////////////////////////////////////////////////////
  // Timer 0 high byte in split mode: timer clock only, timer 1 run bit, no gate

  // Sharing timer 0's clock select keeps both halves on one timebase
  wire th0_inc = split & t1_run_bit & t0_tick;
  wire [8:0] th0_sum = {1'b0, th0_q} + 9'h001;
  wire th0_ovf = th0_inc & th0_sum[8];

  ////////////////////////////////////////////////////////////////////////////////
  // Timer 1

  // Outside split mode timer 1 follows the same run and gate rules as timer 0
  // While timer 0 is split, the mode field alone runs timer 1 and pins are ignored
  wire t1_enable_split = t1_mode_live;
  wire t1_enable_norm = t1_mode_live & t1_run_bit & (~t1_gate | irq1_active);
  wire t1_src_tick = (t1_count_src & ~split) ? pin_fall[PIN_TIMER1_COUNT] : t1_tick;
  wire t1_inc = (split ? t1_enable_split : t1_enable_norm) & t1_src_tick;
  wire [16:0] t1_next = step_timer(t1_mode, tl1_q, th1_q);
  wire t1_ovf = t1_inc & t1_next[16];

  // In split mode the timer 1 flag belongs to the timer 0 high byte
  wire tf1_set = split ? th0_ovf : t1_ovf;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte next values; a software byte write wins over counting in that cycle

  assign tl0_d = i_byte_wr[BYTE_TIMER0_LOW] ? i_byte_wdata :
                 t0_inc ? t0_next[7:0] : tl0_q;
  assign th0_d = i_byte_wr[BYTE_TIMER0_HIGH] ? i_byte_wdata :
                 split ? (th0_inc ? th0_sum[7:0] : th0_q) :
                 t0_inc ? t0_next[15:8] : th0_q;
  assign tl1_d = i_byte_wr[BYTE_TIMER1_LOW] ? i_byte_wdata :
                 t1_inc ? t1_next[7:0] : tl1_q;
  assign th1_d = i_byte_wr[BYTE_TIMER1_HIGH] ? i_byte_wdata :
                 t1_inc ? t1_next[15:8] : th1_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register next value; hardware set wins over any clear

  // A vector acknowledge only clears, so an overflow in the same cycle leaves the flag set
  wire ack_t1 = i_vector_ack[ACK_TIMER1];
  wire ack_t0 = i_vector_ack[ACK_TIMER0];
  wire ack_i1 = i_vector_ack[ACK_EXT_IRQ1];
  wire ack_i0 = i_vector_ack[ACK_EXT_IRQ0];

  wire tf1_keep = ack_t1 ? 1'b0 : i_ctl_wr ? i_ctl_wdata[CTL_TIMER1_OVERFLOW_FLAG] :
                  ctl_q[CTL_TIMER1_OVERFLOW_FLAG];
  wire tf0_keep = ack_t0 ? 1'b0 : i_ctl_wr ? i_ctl_wdata[CTL_TIMER0_OVERFLOW_FLAG] :
                  ctl_q[CTL_TIMER0_OVERFLOW_FLAG];
  wire ie1_keep = ack_i1 ? 1'b0 : i_ctl_wr ? i_ctl_wdata[CTL_EXT_IRQ1_PENDING] :
                  ctl_q[CTL_EXT_IRQ1_PENDING];
  wire ie0_keep = ack_i0 ? 1'b0 : i_ctl_wr ? i_ctl_wdata[CTL_EXT_IRQ0_PENDING] :
                  ctl_q[CTL_EXT_IRQ0_PENDING];

  // Level type: the pending flag tracks the active input, so clearing it has no lasting effect
  wire ie1_next = irq1_type ? (irq1_edge | ie1_keep) : irq1_active;
  wire ie0_next = irq0_type ? (irq0_edge | ie0_keep) : irq0_active;

  always_comb begin
    ctl_d = ctl_q;
    if (i_ctl_wr) begin
      ctl_d[CTL_TIMER1_RUN_BIT] = i_ctl_wdata[CTL_TIMER1_RUN_BIT];
      ctl_d[CTL_TIMER0_RUN_BIT] = i_ctl_wdata[CTL_TIMER0_RUN_BIT];
      ctl_d[CTL_EXT_IRQ1_TYPE_SELECT] = i_ctl_wdata[CTL_EXT_IRQ1_TYPE_SELECT];
      ctl_d[CTL_EXT_IRQ0_TYPE_SELECT] = i_ctl_wdata[CTL_EXT_IRQ0_TYPE_SELECT];
    end
    ctl_d[CTL_TIMER1_OVERFLOW_FLAG] = tf1_set | tf1_keep;
    ctl_d[CTL_TIMER0_OVERFLOW_FLAG] = t0_ovf | tf0_keep;
    ctl_d[CTL_EXT_IRQ1_PENDING] = ie1_next;
    ctl_d[CTL_EXT_IRQ0_PENDING] = ie0_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl_q <= CTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Counter bytes clear on reset so software starts from a known count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tl0_q <= BYTE_RESET;
    end else begin
      tl0_q <= tl0_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      th0_q <= BYTE_RESET;
    end else begin
      th0_q <= th0_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tl1_q <= BYTE_RESET;
    end else begin
      tl1_q <= tl1_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      th1_q <= BYTE_RESET;
    end else begin
      th1_q <= th1_d;
    end
  end

  // Registered tick: the serial ports see it in the same cycle as the wrapped count, one cycle after the overflow
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      baud_q <= 1'b0;
    end else begin
      baud_q <= t1_ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign o_ctl_rdata = ctl_q;
  assign o_timer0_low_byte = tl0_q;
  assign o_timer0_high_byte = th0_q;
  assign o_timer1_low_byte = tl1_q;
  assign o_timer1_high_byte = th1_q;
  // Interrupt requests are the flag bits themselves, so they drop with the flags
  assign o_timer0_irq = ctl_q[CTL_TIMER0_OVERFLOW_FLAG];
  assign o_timer1_irq = ctl_q[CTL_TIMER1_OVERFLOW_FLAG];
  assign o_ext_irq0_irq = ctl_q[CTL_EXT_IRQ0_PENDING];
  assign o_ext_irq1_irq = ctl_q[CTL_EXT_IRQ1_PENDING];
  assign o_timer1_baud_tick = baud_q;

endmodule : timer01_split_mode_and_control

// ===== timer01_split_mode_and_control_bench.sv
// Self-checking bench for the timer 0/1 split-mode and control block
`timescale 1ns/100ps
module timer01_split_mode_and_control_bench;
  import timer01_pkg::*;
  logic i_clk, i_srst, i_ctl_wr, i_timer0_sysclk_select, i_timer1_sysclk_select;
  logic [7:0] i_ctl_wdata, i_timer_mode_register, i_byte_wdata, o_ctl_rdata, v;
  logic [7:0] o_timer0_low_byte, o_timer0_high_byte, o_timer1_low_byte, o_timer1_high_byte;
  logic [3:0] i_byte_wr, i_vector_ack, pins;
  logic i_prescale_tick, i_ext_irq0_polarity, i_ext_irq1_polarity;
  logic o_timer0_irq, o_timer1_irq, o_ext_irq0_irq, o_ext_irq1_irq, o_timer1_baud_tick;
  int err_total = 0;
  int cmp_count = 0;
  pin_source pin_source_i (.i_clk, .o_pins(pins));
  timer01_split_mode_and_control timer01_split_mode_and_control_i (.i_clk, .i_srst, .i_ctl_wr, .i_ctl_wdata,
    .i_timer_mode_register, .i_byte_wr, .i_byte_wdata, .i_timer0_sysclk_select, .i_timer1_sysclk_select,
    .i_prescale_tick, .i_ext_irq0_polarity, .i_ext_irq1_polarity,
    .i_timer0_count_pin(pins[PIN_TIMER0_COUNT]), .i_timer1_count_pin(pins[PIN_TIMER1_COUNT]),
    .i_ext_irq0_input(pins[PIN_EXT_IRQ0]), .i_ext_irq1_input(pins[PIN_EXT_IRQ1]), .i_vector_ack, .o_ctl_rdata,
    .o_timer0_low_byte, .o_timer0_high_byte, .o_timer1_low_byte, .o_timer1_high_byte, .o_timer0_irq,
    .o_timer1_irq, .o_ext_irq0_irq, .o_ext_irq1_irq, .o_timer1_baud_tick);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_ctl(input logic [7:0] d);
    @(negedge i_clk);
    i_ctl_wr = 1'b1;
    i_ctl_wdata = d;
    @(negedge i_clk);
    i_ctl_wr = 1'b0;
  endtask : wr_ctl
  task automatic wr_byte(input int idx, input logic [7:0] d);
    @(negedge i_clk);
    i_byte_wr[idx] = 1'b1;
    i_byte_wdata = d;
    @(negedge i_clk);
    i_byte_wr = 4'h0;
  endtask : wr_byte
  task automatic ack(input int idx);
    @(negedge i_clk);
    i_vector_ack[idx] = 1'b1;
    @(negedge i_clk);
    i_vector_ack = 4'h0;
  endtask : ack
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (6000) @(posedge i_clk);
    err_total++;
    close_out();
  end
  initial begin
    {i_srst, i_ctl_wr, i_ctl_wdata, i_timer_mode_register, i_byte_wr, i_byte_wdata} = '0;
    {i_timer0_sysclk_select, i_timer1_sysclk_select, i_vector_ack, i_prescale_tick} = '0;
    {i_ext_irq0_polarity, i_ext_irq1_polarity} = '0;
    i_srst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_srst = 1'b0;
    chk("ctl reset", 8'h00, o_ctl_rdata);
    wr_ctl(8'h05);
    chk("ctl types", 8'h05, o_ctl_rdata);
    // Split mode, timer 1 in mode 0, both on the system clock
    i_timer_mode_register = 8'h03;
    i_timer0_sysclk_select = 1'b1;
    i_timer1_sysclk_select = 1'b1;
    wr_byte(BYTE_TIMER0_HIGH, 8'hFD);
    wr_ctl(8'h40);
    repeat (20) if (o_timer1_irq !== 1'b1) @(negedge i_clk);
    chk("ctl wrap", 8'hC0, o_ctl_rdata);
    chk("high wrap", 8'h00, o_timer0_high_byte);
    chk("low idle", 8'h00, o_timer0_low_byte);
    chk("t1 runs", 8'h01, {7'h00, o_timer1_low_byte != 8'h00});
    ack(ACK_TIMER1);
    chk("ack flag1", 8'h40, o_ctl_rdata);
    repeat (300) if (o_timer1_irq !== 1'b1) @(negedge i_clk);
    chk("flag1 again", 8'h01, {7'h00, o_timer1_irq});
    wr_ctl(8'h00);
    chk("sw clear", 8'h00, o_ctl_rdata);
    v = o_timer0_high_byte;
    repeat (5) @(negedge i_clk);
    chk("high hold", v, o_timer0_high_byte);
    // High byte on the prescaled clock: it moves only on a prescale tick
    i_timer0_sysclk_select = 1'b0;
    wr_ctl(8'h40);
    v = o_timer0_high_byte;
    repeat (3) @(negedge i_clk);
    chk("high no tick", v, o_timer0_high_byte);
    i_prescale_tick = 1'b1;
    @(negedge i_clk);
    i_prescale_tick = 1'b0;
    chk("high prescaled", v + 8'h01, o_timer0_high_byte);
    wr_ctl(8'h00);
    i_timer0_sysclk_select = 1'b1;
    i_timer_mode_register = 8'h33;
    repeat (2) @(negedge i_clk);
    v = o_timer1_low_byte;
    repeat (10) @(negedge i_clk);
    chk("t1 stop", v, o_timer1_low_byte);
    i_timer_mode_register = 8'h13;
    wr_byte(BYTE_TIMER1_HIGH, 8'hFF);
    wr_byte(BYTE_TIMER1_LOW, 8'hF0);
    repeat (40) if (o_timer1_baud_tick !== 1'b1) @(negedge i_clk);
    chk("baud tick", 8'h01, {7'h00, o_timer1_baud_tick});
    chk("t1 high wrap", 8'h00, o_timer1_high_byte);
    chk("no flag1", 8'h00, o_ctl_rdata);
    // Gated low byte with level-sensed interrupt 0, active low
    i_timer_mode_register = 8'h0B;
    wr_byte(BYTE_TIMER0_LOW, 8'h00);
    wr_ctl(8'h10);
    repeat (10) @(negedge i_clk);
    chk("gate shut", 8'h00, o_timer0_low_byte);
    chk("level idle", 8'h00, {7'h00, o_ext_irq0_irq});
    pin_source_i.set_pin(PIN_EXT_IRQ0, 1'b0);
    repeat (8) @(negedge i_clk);
    chk("level on", 8'h01, {7'h00, o_ext_irq0_irq});
    chk("gate open", 8'h01, {7'h00, o_timer0_low_byte != 8'h00});
    i_ext_irq0_polarity = 1'b1;
    repeat (2) @(negedge i_clk);
    v = o_timer0_low_byte;
    repeat (3) @(negedge i_clk);
    chk("gate polarity", v, o_timer0_low_byte);
    chk("level polarity", 8'h00, {7'h00, o_ext_irq0_irq});
    pin_source_i.set_pin(PIN_EXT_IRQ0, 1'b1);
    i_ext_irq0_polarity = 1'b0;
    // Low byte counting falls of its count pin
    i_timer_mode_register = 8'h07;
    wr_byte(BYTE_TIMER0_LOW, 8'hFF);
    pin_source_i.pulse_low(PIN_TIMER0_COUNT);
    chk("pin count", 8'h00, o_timer0_low_byte);
    chk("flag0 set", 8'h01, {7'h00, o_timer0_irq});
    ack(ACK_TIMER0);
    chk("ack flag0", 8'h00, {7'h00, o_timer0_irq});
    wr_ctl(8'h04);
    pin_source_i.pulse_low(PIN_EXT_IRQ1);
    chk("edge pend", 8'h01, {7'h00, o_ext_irq1_irq});
    ack(ACK_EXT_IRQ1);
    chk("edge ack", 8'h00, {7'h00, o_ext_irq1_irq});
    // Active-high edge type: a fall is ignored, the rise sets the flag
    i_ext_irq1_polarity = 1'b1;
    pin_source_i.set_pin(PIN_EXT_IRQ1, 1'b0);
    repeat (5) @(negedge i_clk);
    chk("rise only", 8'h00, {7'h00, o_ext_irq1_irq});
    pin_source_i.set_pin(PIN_EXT_IRQ1, 1'b1);
    repeat (5) @(negedge i_clk);
    chk("rise pend", 8'h01, {7'h00, o_ext_irq1_irq});
    i_ext_irq1_polarity = 1'b0;
    // Reset again in mid-run: the control register must come back clear
    i_srst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_srst = 1'b0;
    chk("ctl rst again", 8'h00, o_ctl_rdata);
    repeat (2) @(negedge i_clk);
    chk("ctl idle", 8'h00, o_ctl_rdata);
    close_out();
  end
endmodule : timer01_split_mode_and_control_bench
bind timer01_split_mode_and_control timer01_split_mode_and_control_chk chk_i (.i_clk, .i_srst, .i_ctl_wr,
  .i_ctl_wdata, .i_timer_mode_register, .i_byte_wr, .i_timer0_sysclk_select, .i_timer1_sysclk_select,
  .i_vector_ack, .o_ctl_rdata, .o_timer0_low_byte, .o_timer0_high_byte, .o_timer1_low_byte,
  .o_timer1_high_byte, .o_timer0_irq, .o_timer1_irq, .o_timer1_baud_tick);

// ===== timer01_split_mode_and_control_chk.sv
// Port-level assertions for the timer 0/1 split-mode and control block
`timescale 1ns/100ps
module timer01_split_mode_and_control_chk
  import timer01_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_ctl_wdata,
  input wire logic [7:0] i_timer_mode_register,
  input wire logic [3:0] i_byte_wr,
  input wire logic i_timer0_sysclk_select,
  input wire logic i_timer1_sysclk_select,
  input wire logic [3:0] i_vector_ack,
  input wire logic [7:0] o_ctl_rdata,
  input wire logic [7:0] o_timer0_low_byte,
  input wire logic [7:0] o_timer0_high_byte,
  input wire logic [7:0] o_timer1_low_byte,
  input wire logic [7:0] o_timer1_high_byte,
  input wire logic o_timer0_irq,
  input wire logic o_timer1_irq,
  input wire logic o_timer1_baud_tick
);
  wire logic split = i_timer_mode_register[1:0] == 2'b11;
  wire logic t1_off = i_timer_mode_register[5:4] == 2'b11 && i_byte_wr[3:2] == 2'b00;
  wire logic quiet = i_byte_wr == 4'h0 && !i_ctl_wr;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////////////
  ctl_reset_a: assert property (disable iff (1'b0) i_srst |=> o_ctl_rdata == CTL_RESET)
    else $error("control register not zero after reset");
  run_write_a: assert property (i_ctl_wr |=> o_ctl_rdata[6] == $past(i_ctl_wdata[6]) && o_ctl_rdata[4] == $past(i_ctl_wdata[4]))
    else $error("run bits not taken from write");
  irq_flags_a: assert property (o_timer0_irq == o_ctl_rdata[5] && o_timer1_irq == o_ctl_rdata[7])
    else $error("interrupt request differs from flag");
  low_hold_a: assert property (split && !o_ctl_rdata[4] && !i_byte_wr[0] |=> $stable(o_timer0_low_byte))
    else $error("low byte moved without run bit");
  high_hold_a: assert property (split && !o_ctl_rdata[6] && !i_byte_wr[1] |=> $stable(o_timer0_high_byte))
    else $error("high byte moved without timer 1 run bit");
  high_wrap_a: assert property (split && o_ctl_rdata[6] && i_timer0_sysclk_select
    && o_timer0_high_byte == 8'hFF && quiet |=> o_timer0_high_byte == 8'h00 && o_ctl_rdata[7])
    else $error("high byte wrap did not set timer 1 flag");
  no_flag1_a: assert property (split && !i_ctl_wr && (!o_ctl_rdata[6] || o_timer0_high_byte != 8'hFF)
    |=> !$rose(o_ctl_rdata[7]))
    else $error("timer 1 flag set while split");
  t1_stop_a: assert property (t1_off [*2] |=> $stable({o_timer1_high_byte, o_timer1_low_byte}))
    else $error("timer 1 counted in mode three");
  baud_tick_a: assert property (split && i_timer_mode_register[5:4] == 2'b01 && i_timer1_sysclk_select
    && {o_timer1_high_byte, o_timer1_low_byte} == 16'hFFFF && quiet |=> o_timer1_baud_tick)
    else $error("no baud tick after timer 1 overflow");
  t1_ack_a: assert property (split && i_vector_ack[3] && o_timer0_high_byte != 8'hFF && !i_ctl_wr
    |=> !o_ctl_rdata[7])
    else $error("vectoring left timer 1 flag set");
  t0_ack_a: assert property (split && i_vector_ack[1] && o_timer0_low_byte != 8'hFF && !i_ctl_wr
    |=> !o_ctl_rdata[5])
    else $error("vectoring left timer 0 flag set");
  c_wrap: cover property ($rose(o_timer1_irq));
  c_tick: cover property (o_timer1_baud_tick);
  c_low: cover property ($rose(o_timer0_irq));
endmodule : timer01_split_mode_and_control_chk
